// ### src/ncm_top.sv
// Neutral current mismatch detector with its register port and interrupts.
module ncm_top #(
  parameter int SAMPLE_CYCLES = ncm_pkg::SAMPLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [23:0] phase_a_current_sample,
  input wire logic [23:0] phase_b_current_sample,
  input wire logic [23:0] phase_c_current_sample,
  input wire logic [23:0] neutral_current_sample,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic first_interrupt_output_n,
  output logic second_interrupt_output_n
);
  logic tick;
  logic cmp_stb_q;
  logic [27:0] phase_current_sum_q;
  logic [27:0] phase_current_sum_d;
  logic [27:0] neutral_q;
  logic [27:0] abs_sum;
  logic [27:0] abs_neutral;
  logic [28:0] diff;
  logic [28:0] abs_diff;
  logic [23:0] mismatch_threshold_q;
  logic [27:0] thr_ext;
  logic thr_positive;
  logic mismatch_cond;
  logic first_status_q;
  logic first_status_d;
  logic second_status_q;
  logic second_status_d;
  logic first_mask_q;
  logic first_mask_d;
  logic second_mask_q;
  logic second_mask_d;
  logic wr_first_status;
  logic wr_second_status;

  // Sample-period timing for the whole computation.
  ncm_tick #(
    .PERIOD(SAMPLE_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Sign-extend each 24-bit sample before adding, so the sum cannot wrap.
  always_comb
  begin
    phase_current_sum_d = {{4{phase_a_current_sample[23]}}, phase_a_current_sample}
                        + {{4{phase_b_current_sample[23]}}, phase_b_current_sample}
                        + {{4{phase_c_current_sample[23]}}, phase_c_current_sample};
  end

  // Capture the sum and the neutral sample once per sample period.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_current_sum_q <= 28'h0000000;
      neutral_q <= 28'h0000000;
    end
    else if (tick)
    begin
      phase_current_sum_q <= phase_current_sum_d;
      neutral_q <= {{4{neutral_current_sample[23]}}, neutral_current_sample};
    end
  end

  // The comparison runs one cycle after the capture, on registered operands.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_stb_q <= 1'b0;
    end
    else
    begin
      cmp_stb_q <= tick;
    end
  end

  // Magnitudes of the sum and of the neutral sample.
  ncm_abs #(
    .W(28)
  ) u_abs_sum (
    .value(phase_current_sum_q),
    .magnitude(abs_sum)
  );

  ncm_abs #(
    .W(28)
  ) u_abs_neutral (
    .value(neutral_q),
    .magnitude(abs_neutral)
  );

  // One extra bit keeps the difference of two magnitudes exact.
  always_comb
  begin
    diff = {1'b0, abs_sum} - {1'b0, abs_neutral};
  end

  ncm_abs #(
    .W(29)
  ) u_abs_diff (
    .value(diff),
    .magnitude(abs_diff)
  );

  // A zero or negative threshold flags every comparison, even a zero difference.
  always_comb
  begin
    thr_ext = {{4{mismatch_threshold_q[23]}}, mismatch_threshold_q};
    thr_positive = !mismatch_threshold_q[23] && (mismatch_threshold_q != 24'h000000);
    mismatch_cond = !thr_positive || (abs_diff > {5'h00, mismatch_threshold_q});
  end

  // Register write decode for the flag clears.
  always_comb
  begin
    wr_first_status = reg_wr && (reg_addr == ncm_pkg::OFS_FIRST_STATUS)
                    && reg_wdata[ncm_pkg::DONE_BIT];
    wr_second_status = reg_wr && (reg_addr == ncm_pkg::OFS_SECOND_STATUS)
                     && reg_wdata[ncm_pkg::MISMATCH_BIT];
  end

  // Sticky flags: a set in the same cycle as a clear wins, so no event is lost.
  always_comb
  begin
    first_status_d = cmp_stb_q || (first_status_q && !wr_first_status);
    second_status_d = (cmp_stb_q && mismatch_cond)
                    || (second_status_q && !wr_second_status);
  end

  // Status flags.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_status_q <= 1'b0;
      second_status_q <= 1'b0;
    end
    else
    begin
      first_status_q <= first_status_d;
      second_status_q <= second_status_d;
    end
  end

  // Mask writes take only the defined bit of each mask register.
  always_comb
  begin
    first_mask_d = first_mask_q;
    second_mask_d = second_mask_q;
    if (reg_wr && (reg_addr == ncm_pkg::OFS_FIRST_MASK))
    begin
      first_mask_d = reg_wdata[ncm_pkg::DONE_BIT];
    end
    if (reg_wr && (reg_addr == ncm_pkg::OFS_SECOND_MASK))
    begin
      second_mask_d = reg_wdata[ncm_pkg::MISMATCH_BIT];
    end
  end

  // Mask registers.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_mask_q <= 1'b0;
      second_mask_q <= 1'b0;
    end
    else
    begin
      first_mask_q <= first_mask_d;
      second_mask_q <= second_mask_d;
    end
  end

  // The threshold shares the ADC scale; FULL_SCALE puts detection at full scale.
  // Reset leaves it at zero, which flags continuously until software sets it.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mismatch_threshold_q <= ncm_pkg::THR_RESET;
    end
    else if (reg_wr && (reg_addr == ncm_pkg::OFS_MISMATCH_THRESHOLD))
    begin
      mismatch_threshold_q <= reg_wdata[23:0];
    end
  end

  // Interrupt pins are active low, built from next-state values so they
  // move in the same cycle as the flags they reflect.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_interrupt_output_n <= 1'b1;
      second_interrupt_output_n <= 1'b1;
    end
    else
    begin
      first_interrupt_output_n <= !(first_status_d && first_mask_d);
      second_interrupt_output_n <= !(second_status_d && second_mask_d);
    end
  end

  // Read data appear the cycle after the strobe and read as zero otherwise.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 32'h00000000;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ncm_pkg::OFS_PHASE_CURRENT_SUM: reg_rdata <= {4'h0, phase_current_sum_q};
        ncm_pkg::OFS_MISMATCH_THRESHOLD: reg_rdata <= {4'h0, thr_ext};
        ncm_pkg::OFS_FIRST_STATUS: reg_rdata <= 32'(first_status_q) << ncm_pkg::DONE_BIT;
        ncm_pkg::OFS_SECOND_STATUS: reg_rdata <= 32'(second_status_q) << ncm_pkg::MISMATCH_BIT;
        ncm_pkg::OFS_FIRST_MASK: reg_rdata <= 32'(first_mask_q) << ncm_pkg::DONE_BIT;
        ncm_pkg::OFS_SECOND_MASK: reg_rdata <= 32'(second_mask_q) << ncm_pkg::MISMATCH_BIT;
        default: reg_rdata <= 32'h00000000;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Checks on the computation, the flags and the register port.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Helper: the expected sum computed independently from the samples.
  logic [27:0] ref_sum;
  always_comb
  begin
    ref_sum = 28'($signed(phase_a_current_sample)) + 28'($signed(phase_b_current_sample))
            + 28'($signed(phase_c_current_sample));
  end

  // Capture then compare, one cycle apart.
  sequence s_capture;
    tick;
  endsequence

  sequence s_compare;
    s_capture ##1 cmp_stb_q;
  endsequence

  a_sum_capture: assert property (s_capture |=> phase_current_sum_q == $past(ref_sum))
    else $error("phase current sum does not match the captured samples");

  a_sum_holds: assert property (!tick |=> $stable(phase_current_sum_q))
    else $error("phase current sum changed outside a sample tick");

  a_tick_period: assert property (tick |=> !tick)
    else $error("sample tick lasted more than one cycle");

  a_done_flag_set: assert property (s_compare |=> first_status_q)
    else $error("computation done flag not set after a comparison");

  a_mismatch_sets: assert property (cmp_stb_q && mismatch_cond |=> second_status_q)
    else $error("mismatch flag not set when the difference exceeds the threshold");

  a_no_false_flag: assert property (
    !second_status_q && !(cmp_stb_q && abs_diff > {5'h00, mismatch_threshold_q})
    && thr_positive |=> !second_status_q)
    else $error("mismatch flag set while within threshold");

  a_nonpos_threshold: assert property (
    cmp_stb_q && (mismatch_threshold_q[23] || mismatch_threshold_q == 24'h000000)
    |=> second_status_q)
    else $error("zero or negative threshold did not flag a mismatch");

  a_irq_follows: assert property (
    second_interrupt_output_n == !(second_status_q && second_mask_q))
    else $error("second interrupt output disagrees with masked flag");

  a_flag_clear: assert property (
    wr_second_status && !cmp_stb_q |=> !second_status_q && second_interrupt_output_n)
    else $error("write of one did not clear the mismatch flag and release the pin");

  a_flag_sticky: assert property (
    second_status_q && !wr_second_status |=> second_status_q)
    else $error("mismatch flag dropped without a software clear");

  a_sum_readback: assert property (
    reg_rd && reg_addr == ncm_pkg::OFS_PHASE_CURRENT_SUM
    |=> reg_rdata == {4'h0, $past(phase_current_sum_q)})
    else $error("phase current sum read is not zero padded");

  a_thr_readback: assert property (
    reg_rd && reg_addr == ncm_pkg::OFS_MISMATCH_THRESHOLD
    |=> reg_rdata[31:28] == 4'h0 && reg_rdata[27:23] == {5{$past(mismatch_threshold_q[23])}}
    && reg_rdata[22:0] == $past(mismatch_threshold_q[22:0]))
    else $error("threshold read is not sign extended to 28 bits");

  // Helper: cycles since the last tick. Reset starts it one below zero so the
  // first period, which begins at release, is counted like every later one.
  logic [31:0] since_tick_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      since_tick_q <= 32'hFFFFFFFF;
    end
    else
    begin
      since_tick_q <= tick ? 32'h00000000 : since_tick_q + 32'h00000001;
    end
  end

  a_tick_spacing: assert property (tick |-> since_tick_q == 32'(SAMPLE_CYCLES - 1))
    else $error("sample tick spacing differs from the sample period");

  a_thr_write: assert property (
    reg_wr && reg_addr == ncm_pkg::OFS_MISMATCH_THRESHOLD
    |=> mismatch_threshold_q == $past(reg_wdata[23:0]))
    else $error("threshold write did not land in the register");

  a_done_irq: assert property (
    first_interrupt_output_n == !(first_status_q && first_mask_q))
    else $error("first interrupt output disagrees with masked done flag");

  a_done_clear: assert property (wr_first_status && !cmp_stb_q |=> !first_status_q)
    else $error("write of one did not clear the done flag");

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside the answering cycle");
endmodule // ncm_top

// ### src/ncm_pkg.sv
// Constants shared by the neutral current mismatch block.
package ncm_pkg;
  // Data path widths.
  localparam int SAMPLE_W = 24;
  localparam int SUM_W = 28;
  localparam int THR_W = 24;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  // Register offsets on the plain register port.
  localparam logic [3:0] OFS_PHASE_CURRENT_SUM = 4'h0;
  localparam logic [3:0] OFS_MISMATCH_THRESHOLD = 4'h1;
  localparam logic [3:0] OFS_FIRST_STATUS = 4'h2;
  localparam logic [3:0] OFS_SECOND_STATUS = 4'h3;
  localparam logic [3:0] OFS_FIRST_MASK = 4'h4;
  localparam logic [3:0] OFS_SECOND_MASK = 4'h5;
  // Field positions.
  localparam int DONE_BIT = 17;
  localparam int MISMATCH_BIT = 20;
  // Reset values and scale.
  localparam logic [23:0] THR_RESET = 24'h000000;
  localparam logic [23:0] FULL_SCALE = 24'h5A7540;
  // Sample timing: 125 us period at a 10 ns clock.
  localparam int SAMPLE_PERIOD_NS = 125000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// ### src/ncm_abs.sv
// Two's complement magnitude of a signed word.
module ncm_abs #(
  parameter int W = 28
) (
  input wire logic [W-1:0] value,
  output logic [W-1:0] magnitude
);
  // The most negative code cannot occur here: callers leave one bit of headroom.
  always_comb
  begin
    magnitude = value[W-1] ? (~value + {{(W-1){1'b0}}, 1'b1}) : value;
  end
endmodule // ncm_abs

// ### src/ncm_tick.sv
// Free-running divider that marks each sample period with a one-cycle pulse.
module ncm_tick #(
  parameter int PERIOD = ncm_pkg::SAMPLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  output logic tick
);
  logic [$clog2(PERIOD)-1:0] cnt_q;
  localparam logic [$clog2(PERIOD)-1:0] LAST = ($clog2(PERIOD))'(PERIOD - 1);

  // Counter wraps at the end of each period and pulses the tick.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule // ncm_tick

// ### tb/ncm_host.sv
// Host controller model that reaches the mismatch block through its register port.
module ncm_host (
  input wire logic mclk,
  input wire logic [31:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero.
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write; idle data is inverted so stale values are never mistaken for valid ones.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One-cycle read; data is taken once the answering edge has settled.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // A positive level stops the event firing every period after reset.
  task automatic init_threshold(input logic [23:0] thr);
    wr(ncm_pkg::OFS_MISMATCH_THRESHOLD, {8'h00, thr});
  endtask
  // Writing one to the flag bit acknowledges it.
  task automatic clear_mismatch();
    wr(ncm_pkg::OFS_SECOND_STATUS, 32'h00100000);
  endtask
endmodule // ncm_host

// ### tb/tb_top.sv
// Self-checking bench for the neutral current mismatch block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 16;
  typedef struct {
    logic [23:0] a;
    logic [23:0] b;
    logic [23:0] c;
    logic [23:0] n;
    logic [23:0] thr;
    logic flag;
  } ncm_row_s;
  logic mclk;
  logic rst_n;
  logic [23:0] pa, pb, pc, pn;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic done_int_n;
  logic mis_int_n;
  logic [31:0] got;
  logic [27:0] esum;
  int err_count;
  int num_checks;
  realtime t1;
  realtime t2;
  // Samples, threshold and the flag they should give.
  ncm_row_s rows [9] = '{
    '{24'h000001, 24'h000002, 24'h000003, 24'h000006, 24'h000005, 1'b0},
    '{24'h7FFFFF, 24'h7FFFFF, 24'h7FFFFF, 24'h000000, 24'h5A7540, 1'b1},
    '{24'h800000, 24'h800000, 24'h800000, 24'h800000, 24'h7FFFFF, 1'b1},
    '{24'h00000A, 24'h000000, 24'h000000, 24'hFFFFFC, 24'h000006, 1'b0},
    '{24'h00000A, 24'h000000, 24'h000000, 24'hFFFFFC, 24'h000005, 1'b1},
    '{24'h5A7540, 24'h000000, 24'h000000, 24'h000000, 24'h5A7540, 1'b0},
    '{24'h5A7541, 24'h000000, 24'h000000, 24'h000000, 24'h5A7540, 1'b1},
    '{24'h000001, 24'h000002, 24'h000003, 24'h000006, 24'h000000, 1'b1},
    '{24'h000001, 24'h000002, 24'h000003, 24'h000006, 24'hFFFFFF, 1'b1}
  };
  // Free-running 100 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ncm_top #(.SAMPLE_CYCLES(PER)) u_ncm_top (
    .mclk(mclk), .rst_n(rst_n), .phase_a_current_sample(pa), .phase_b_current_sample(pb),
    .phase_c_current_sample(pc), .neutral_current_sample(pn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_interrupt_output_n(done_int_n), .second_interrupt_output_n(mis_int_n));
  ncm_host u_ncm_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  // Word comparison; case inequality so unknowns never match.
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Pin comparison.
  task automatic chk_pin(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Waits whole cycles, then lets the edge's updates land.
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic drive(input ncm_row_s r);
    @(posedge mclk);
    pa <= r.a;
    pb <= r.b;
    pc <= r.c;
    pn <= r.n;
  endtask
  // Polls on the falling edge so the registered pin is already settled.
  task automatic wait_done(output realtime t);
    for (int k = 0; k < 100 && done_int_n !== 1'b0; k++)
      @(negedge mclk);
    t = $realtime;
  endtask
  // Main sequence.
  initial
  begin
    err_count = 0;
    num_checks = 0;
    rst_n = 1'b0;
    pa = 24'h0;
    pb = 24'h0;
    pc = 24'h0;
    pn = 24'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    u_ncm_host.rd(ncm_pkg::OFS_MISMATCH_THRESHOLD, got);
    chk_word(got, 32'h0);
    chk_pin(mis_int_n, 1'b1);
    u_ncm_host.init_threshold(24'h000100);
    foreach (rows[i])
    begin
      drive(rows[i]);
      u_ncm_host.wr(ncm_pkg::OFS_MISMATCH_THRESHOLD, {8'h00, rows[i].thr});
      settle(40);
      u_ncm_host.clear_mismatch();
      settle(40);
      esum = {{4{rows[i].a[23]}}, rows[i].a} + {{4{rows[i].b[23]}}, rows[i].b}
        + {{4{rows[i].c[23]}}, rows[i].c};
      u_ncm_host.rd(ncm_pkg::OFS_PHASE_CURRENT_SUM, got);
      chk_word(got, {4'h0, esum});
      u_ncm_host.rd(ncm_pkg::OFS_MISMATCH_THRESHOLD, got);
      chk_word(got, {4'h0, {4{rows[i].thr[23]}}, rows[i].thr});
      u_ncm_host.rd(ncm_pkg::OFS_SECOND_STATUS, got);
      chk_word(got, {11'h0, rows[i].flag, 20'h0});
    end
    // The sum is read-only and unmapped offsets read zero.
    u_ncm_host.wr(ncm_pkg::OFS_PHASE_CURRENT_SUM, 32'h0FFFFFFF);
    u_ncm_host.rd(ncm_pkg::OFS_PHASE_CURRENT_SUM, got);
    chk_word(got, 32'h00000006);
    u_ncm_host.rd(4'hF, got);
    chk_word(got, 32'h0);
    // Negative level keeps the flag set; unmasking pulls the pin low.
    u_ncm_host.wr(ncm_pkg::OFS_SECOND_MASK, 32'h00100000);
    settle(2);
    chk_pin(mis_int_n, 1'b0);
    u_ncm_host.rd(ncm_pkg::OFS_SECOND_MASK, got);
    chk_word(got, 32'h00100000);
    u_ncm_host.wr(ncm_pkg::OFS_MISMATCH_THRESHOLD, {8'h00, ncm_pkg::FULL_SCALE});
    settle(40);
    chk_pin(mis_int_n, 1'b0);
    u_ncm_host.clear_mismatch();
    settle(2);
    chk_pin(mis_int_n, 1'b1);
    u_ncm_host.rd(ncm_pkg::OFS_SECOND_STATUS, got);
    chk_word(got, 32'h0);
    // Done flag and its pin; two sets are one sample period apart.
    u_ncm_host.wr(ncm_pkg::OFS_FIRST_MASK, 32'h00020000);
    settle(20);
    u_ncm_host.rd(ncm_pkg::OFS_FIRST_STATUS, got);
    chk_word(got, 32'h00020000);
    // A set landing on the clear wins, so repeat the clear until the pin lets go;
    // only then does the next low edge mark the start of a period.
    for (int k = 0; k < 4 && done_int_n !== 1'b1; k++)
      u_ncm_host.wr(ncm_pkg::OFS_FIRST_STATUS, 32'h00020000);
    wait_done(t1);
    u_ncm_host.wr(ncm_pkg::OFS_FIRST_STATUS, 32'h00020000);
    settle(1);
    chk_pin(done_int_n, 1'b1);
    wait_done(t2);
    chk_word(32'(int'(t2 - t1)), 32'(PER * 10));
    // Second reset in mid-run brings the zero level back.
    @(posedge mclk);
    rst_n <= 1'b0;
    settle(3);
    chk_pin(mis_int_n, 1'b1);
    chk_pin(done_int_n, 1'b1);
    @(posedge mclk);
    rst_n <= 1'b1;
    u_ncm_host.rd(ncm_pkg::OFS_MISMATCH_THRESHOLD, got);
    chk_word(got, 32'h0);
    settle(40);
    u_ncm_host.rd(ncm_pkg::OFS_SECOND_STATUS, got);
    chk_word(got, 32'h00100000);
    tally_and_finish();
  end
  // Watchdog well beyond the roughly one thousand cycles the sequence needs.
  initial
  begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule // tb_top
